// *** src/nvram_cmd_status.sv ***
// Serial nvram command decoder, write latch, status register and power modes
//
// Functional notes
// [RULE1] Pause starts on pause low, select low, clock low
// [RULE2] Pause ends on pause high with clock low
// [RULE3] Paused: output tri-stated, clock and input ignored
// [RULE4] Pause keeps bit sequence; operation resumes afterwards
// [RULE5] Deselect during pause resets the serial interface
// [RULE6] Opcode byte captured MSB first per frame
// [RULE7] 0x06 sets, 0x04 clears write latch
// [RULE8] 0x05 status read, 0x01 status write
// [RULE9] 0x03 array read, 0x13 checked read
// [RULE10] 0x02 array write, 0x12 checked write
// [RULE11] 0x08 store, 0x09 recall
// [RULE12] 0xC2/0xC3 serial number, 0xB9 deep sleep
// [RULE13] Sleep on deselect; select wakes after delay
// [RULE14] Latch clear at reset; writes need latch
// [RULE15] Latch commands act only on bare opcode frames
// [RULE16] Latch cleared by clear command and write completions
// [RULE17] Status bit 1 mirrors latch; gates writes
// [RULE18] Status bit 0 shows store/recall busy
// [RULE19] Status bit 4 reports last checked write
// [RULE20] Status bit 5 selects rollover; bit 6 unused
// [RULE21] Bits 3:2 protect level blocks array writes
// [RULE22] Bit 7 plus guard pin low locks status
// [RULE23] Sample rising edge, drive after falling edge
// [RULE24] Unknown opcode: ignore input, output stays off
// [RULE25] Status write leaves bits 4, 1, 0 alone
// [RULE26] Frames under eight bits execute nothing
module nvram_cmd_status (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  input wire logic spi_pause_n,
  input wire logic guard_pin_n,
  input wire logic nv_busy,
  input wire logic crc_done,
  input wire logic crc_bad,
  output logic spi_so,
  output logic spi_so_oe,
  output logic [7:0] device_status_control_r,
  output logic hardware_lock_mode_r,
  output nvram_pkg::power_mode_t power_mode_r,
  output logic wake_busy_r,
  output logic array_write_go_r,
  output logic checked_write_go_r,
  output logic store_go_r,
  output logic recall_go_r,
  output logic serial_number_write_go_r,
  output logic write_refused_r,
  output logic [14:0] write_addr_r
);
  logic cs_s;
  logic cs_d_r;
  logic pause_s;
  logic guard_s;
  logic drive_s;
  logic [5:0] cnt;
  logic [7:0] opcode;
  logic [7:0] data_byte;
  logic [15:0] addr;
  logic reject;
  logic link_so;
  logic link_drive;
  logic latch_r;
  logic fail_r;
  logic deep_sleep_r;
  logic [7:0] nv_r;
  logic [nvram_pkg::WAKE_W-1:0] wake_cnt_r;
  logic cs_rise;
  logic cs_fall;
  logic exec;
  logic hw_lock;
  logic bare_op;
  logic write_done;
  logic prot;
  logic st_wr_ok;
  logic wr_cmd;
  logic chk_cmd;
  logic sn_cmd;
  logic refuse;

  bit_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .clk(core_clk), .rst(rst), .ce(ce), .d(spi_cs_n), .q(cs_s)
  );
  bit_sync #(.RST_VAL(1'b1)) u_pause_sync (
    .clk(core_clk), .rst(rst), .ce(ce), .d(spi_pause_n), .q(pause_s)
  );
  bit_sync #(.RST_VAL(1'b1)) u_guard_sync (
    .clk(core_clk), .rst(rst), .ce(ce), .d(guard_pin_n), .q(guard_s)
  );
  bit_sync #(.RST_VAL(1'b0)) u_drive_sync (
    .clk(core_clk), .rst(rst), .ce(ce), .d(link_drive), .q(drive_s)
  );

  // Link registers are quasi-static once the frame has ended
  spi_link u_link (
    .sclk(spi_sclk),
    .rst(rst),
    .cs_n(spi_cs_n),
    .pause_n(spi_pause_n),
    .si(spi_si),
    .status_in(device_status_control_r),
    .cnt_r(cnt),
    .opcode_r(opcode),
    .data_r(data_byte),
    .addr_r(addr),
    .reject_r(reject),
    .so_r(link_so),
    .drive_r(link_drive)
  );

  assign spi_so = link_so;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_d_r <= 1'b1;
    end else if (ce) begin
      cs_d_r <= cs_s;
    end
  end

  assign cs_rise = cs_s && !cs_d_r;
  assign cs_fall = !cs_s && cs_d_r;
  // Frames seen in deep sleep or during the wake delay are dropped
  assign exec = cs_rise && !reject && cnt >= nvram_pkg::BITS_OPCODE &&
                !deep_sleep_r && !wake_busy_r; // [RULE26] [RULE24] [RULE13]
  assign bare_op = cnt == nvram_pkg::BITS_OPCODE; // [RULE15]
  assign write_done = cnt >= nvram_pkg::BITS_WRITE_MIN && cnt[2:0] == 3'd0;
  assign hw_lock = nv_r[nvram_pkg::ST_GUARD] && !guard_s; // [RULE22]
  assign prot = nvram_pkg::addr_protected(nv_r[nvram_pkg::ST_PROT_HI:nvram_pkg::ST_PROT_LO],
                                          addr[14:0]); // [RULE21]
  assign st_wr_ok = exec && opcode == nvram_pkg::OP_ST_WR &&
                    cnt == nvram_pkg::BITS_ONE_BYTE && latch_r && !hw_lock; // [RULE8] [RULE22]
  assign wr_cmd = exec && opcode == nvram_pkg::OP_WR && write_done; // [RULE10]
  assign chk_cmd = exec && opcode == nvram_pkg::OP_CHK_WR && write_done; // [RULE10]
  assign sn_cmd = exec && opcode == nvram_pkg::OP_SN_WR && cnt >= nvram_pkg::BITS_ONE_BYTE &&
                  cnt[2:0] == 3'd0; // [RULE12]
  assign refuse = ((wr_cmd || chk_cmd) && (!latch_r || prot)) || (sn_cmd && !latch_r) ||
                  (exec && opcode == nvram_pkg::OP_ST_WR && !st_wr_ok); // [RULE17]

  // Write latch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latch_r <= 1'b0; // [RULE14]
    end else if (ce && exec) begin
      if (opcode == nvram_pkg::OP_SET_WL && bare_op) begin
        latch_r <= 1'b1; // [RULE7]
      end else if (opcode == nvram_pkg::OP_CLR_WL && bare_op) begin
        latch_r <= 1'b0; // [RULE7] [RULE15] [RULE16]
      end else if (st_wr_ok || wr_cmd || chk_cmd) begin
        latch_r <= 1'b0; // [RULE16]
      end
    end
  end

  // Non-volatile status bits; bit 6 is masked and reads zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_r <= nvram_pkg::NV_RESET;
    end else if (ce && st_wr_ok) begin
      nv_r <= data_byte & nvram_pkg::NV_MASK; // [RULE20] [RULE21] [RULE25]
    end
  end

  // Checked write result: a failure report wins over the clear at start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fail_r <= 1'b0;
    end else if (ce) begin
      if (crc_done && crc_bad) begin
        fail_r <= 1'b1; // [RULE19]
      end else if ((chk_cmd && latch_r && !prot) || (crc_done && !crc_bad)) begin
        fail_r <= 1'b0; // [RULE19]
      end
    end
  end

  // Shadow only moves while deselected so a status read shifts one stable word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      device_status_control_r <= nvram_pkg::STATUS_RESET;
    end else if (ce && cs_s) begin
      device_status_control_r <= nv_r;
      device_status_control_r[nvram_pkg::ST_FAIL] <= fail_r; // [RULE19]
      device_status_control_r[nvram_pkg::ST_LATCH] <= latch_r; // [RULE17]
      device_status_control_r[nvram_pkg::ST_BUSY] <= nv_busy; // [RULE18]
    end
  end

  // Command strobes toward the array, store and serial number engines
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      array_write_go_r <= 1'b0;
      checked_write_go_r <= 1'b0;
      store_go_r <= 1'b0;
      recall_go_r <= 1'b0;
      serial_number_write_go_r <= 1'b0;
      write_refused_r <= 1'b0;
      write_addr_r <= 15'h0000;
    end else if (ce) begin
      array_write_go_r <= wr_cmd && latch_r && !prot; // [RULE14] [RULE21]
      checked_write_go_r <= chk_cmd && latch_r && !prot; // [RULE14] [RULE21]
      store_go_r <= exec && opcode == nvram_pkg::OP_STORE && bare_op; // [RULE11]
      recall_go_r <= exec && opcode == nvram_pkg::OP_RECALL && bare_op; // [RULE11]
      serial_number_write_go_r <= sn_cmd && latch_r; // [RULE17]
      write_refused_r <= refuse;
      if (wr_cmd || chk_cmd) begin
        write_addr_r <= addr[14:0];
      end
    end
  end

  // Deep sleep entry on deselect and timed wake
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      deep_sleep_r <= 1'b0;
      wake_cnt_r <= '0;
    end else if (ce) begin
      if (exec && opcode == nvram_pkg::OP_SLEEP && bare_op) begin
        deep_sleep_r <= 1'b1; // [RULE12] [RULE13]
      end else if (cs_fall && deep_sleep_r) begin
        deep_sleep_r <= 1'b0; // [RULE13]
        wake_cnt_r <= nvram_pkg::WAKE_W'(nvram_pkg::WAKE_CYCLES);
      end else if (wake_cnt_r != '0) begin
        wake_cnt_r <= wake_cnt_r - 1'b1;
      end
    end
  end

  // Output enable lags the pins by the synchroniser; pause or deselect cut it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      spi_so_oe <= 1'b0;
      hardware_lock_mode_r <= 1'b0;
      wake_busy_r <= 1'b0;
      power_mode_r <= nvram_pkg::PM_STANDBY;
    end else if (ce) begin
      // Raw pins stay out of core logic, so the cut waits for the synchronisers
      spi_so_oe <= drive_s && !cs_s && pause_s; // [RULE3] [RULE24]
      hardware_lock_mode_r <= hw_lock; // [RULE22]
      wake_busy_r <= wake_cnt_r > nvram_pkg::WAKE_W'(1);
      if (deep_sleep_r) begin
        power_mode_r <= nvram_pkg::PM_DEEP_SLEEP;
      end else if (cs_s) begin
        power_mode_r <= nvram_pkg::PM_STANDBY;
      end else begin
        power_mode_r <= nvram_pkg::PM_OPERATING;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_set_frame;
    ce && exec && opcode == nvram_pkg::OP_SET_WL && bare_op;
  endsequence
  sequence s_wake_entry;
    ce && cs_fall && deep_sleep_r;
  endsequence
  sequence s_sleep_frame;
    ce && exec && opcode == nvram_pkg::OP_SLEEP && bare_op;
  endsequence

  a_latch_set: assert property (s_set_frame |=> latch_r) // [RULE7]
    else $error("set command did not set the write latch");
  a_latch_clear: assert property (ce && exec && opcode == nvram_pkg::OP_CLR_WL && bare_op
    |=> !latch_r) // [RULE16]
    else $error("clear command left the write latch set");
  a_short_frame: assert property (ce && cs_rise && cnt < nvram_pkg::BITS_OPCODE
    |=> $stable(latch_r) && $stable(nv_r) && !store_go_r && !array_write_go_r) // [RULE26]
    else $error("partial opcode frame changed state");
  a_status_unlatched: assert property (ce && exec && opcode == nvram_pkg::OP_ST_WR && !latch_r
    |=> $stable(nv_r) && write_refused_r) // [RULE17]
    else $error("status write accepted without latch");
  a_status_locked: assert property (ce && exec && opcode == nvram_pkg::OP_ST_WR && hw_lock
    |=> $stable(nv_r)) // [RULE22]
    else $error("status write accepted under hardware lock");
  a_status_volatile: assert property (ce && st_wr_ok && !crc_done
    |=> $stable(fail_r) && !latch_r && nv_r[6] == 1'b0) // [RULE25]
    else $error("status write touched volatile bits");
  a_latch_mirror: assert property (ce && cs_s
    |=> device_status_control_r[nvram_pkg::ST_LATCH] == $past(latch_r)) // [RULE17]
    else $error("status bit 1 does not follow the latch");
  a_fail_report: assert property (ce && crc_done && crc_bad // [RULE19]
    |=> fail_r ##1 (!$past(ce) || !$past(cs_s) ||
    device_status_control_r[nvram_pkg::ST_FAIL]))
    else $error("checked write failure not reported");
  a_wake_delay: assert property (s_wake_entry
    |=> !deep_sleep_r && wake_cnt_r == nvram_pkg::WAKE_W'(nvram_pkg::WAKE_CYCLES)) // [RULE13]
    else $error("wake delay not started on select");
  a_pause_quiet: assert property (ce && !pause_s |=> !spi_so_oe) // [RULE3]
    else $error("output driven during pause");
  a_write_needs: assert property (array_write_go_r || checked_write_go_r
    |-> $past(latch_r) && !$past(prot)) // [RULE14] [RULE21]
    else $error("array write issued without latch or into protected block");
  a_write_ends: assert property (ce && (wr_cmd || chk_cmd) |=> !latch_r) // [RULE16]
    else $error("write completion left latch set");

  // Decode, strobe and status mirror guards
  a_sleep_entry: assert property (s_sleep_frame // [RULE13]
    |=> deep_sleep_r)
    else $error("sleep command did not arm deep sleep");
  a_sleep_mode: assert property (ce && deep_sleep_r // [RULE13]
    |=> power_mode_r == nvram_pkg::PM_DEEP_SLEEP)
    else $error("deep sleep not reported as power mode");
  a_wake_drops: assert property (ce && cs_rise && wake_busy_r // [RULE13]
    |=> $stable(latch_r) && $stable(nv_r) && !array_write_go_r)
    else $error("frame executed during the wake delay");
  a_store_decode: assert property (store_go_r // [RULE11]
    |-> $past(opcode) == nvram_pkg::OP_STORE && $past(cnt) == nvram_pkg::BITS_OPCODE)
    else $error("store strobe without a bare store opcode");
  a_recall_decode: assert property (recall_go_r // [RULE11]
    |-> $past(opcode) == nvram_pkg::OP_RECALL && $past(cnt) == nvram_pkg::BITS_OPCODE)
    else $error("recall strobe without a bare recall opcode");
  a_serial_latch: assert property (serial_number_write_go_r // [RULE17]
    |-> $past(latch_r) && $past(opcode) == nvram_pkg::OP_SN_WR)
    else $error("serial number write issued without latch");
  a_unknown_idle: assert property (ce && cs_rise && reject // [RULE24]
    |=> $stable(latch_r) && $stable(nv_r) && !store_go_r && !recall_go_r)
    else $error("unknown opcode frame changed state");
  a_latch_bare: assert property (ce && exec && !bare_op // [RULE15]
    && opcode == nvram_pkg::OP_SET_WL |=> $stable(latch_r))
    else $error("set command with trailing bytes changed the latch");
  a_protect_refuse: assert property (ce && wr_cmd && prot // [RULE21]
    |=> !array_write_go_r && write_refused_r)
    else $error("write into protected block not refused");
  a_unlatched_refuse: assert property (ce && wr_cmd && !latch_r // [RULE14]
    |=> !array_write_go_r && write_refused_r)
    else $error("array write without latch not refused");
  a_checked_refuse: assert property (ce && chk_cmd && (!latch_r || prot) // [RULE17]
    |=> !checked_write_go_r && write_refused_r)
    else $error("checked write not refused");
  a_fail_clear: assert property (ce && crc_done && !crc_bad // [RULE19]
    |=> !fail_r)
    else $error("good checked write left the fail bit set");
  a_busy_mirror: assert property (ce && cs_s // [RULE18]
    |=> device_status_control_r[nvram_pkg::ST_BUSY] == $past(nv_busy))
    else $error("status bit 0 does not follow the busy input");
  a_spare_zero: assert property (ce && cs_s // [RULE20]
    |=> device_status_control_r[6] == 1'b0)
    else $error("status bit 6 read as one");
  a_lock_mode: assert property (ce && nv_r[nvram_pkg::ST_GUARD] && !guard_s // [RULE22]
    |=> hardware_lock_mode_r)
    else $error("hardware lock not reported");
endmodule

// *** src/nvram_pkg.sv ***
// Shared constants, types and decode helpers for the serial nvram front end
package nvram_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_DELAY_NS = 20000;
  localparam int WAKE_CYCLES = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_W = 12;

  localparam logic [7:0] OP_SET_WL = 8'h06;
  localparam logic [7:0] OP_CLR_WL = 8'h04;
  localparam logic [7:0] OP_ST_RD = 8'h05;
  localparam logic [7:0] OP_ST_WR = 8'h01;
  localparam logic [7:0] OP_RD = 8'h03;
  localparam logic [7:0] OP_CHK_RD = 8'h13;
  localparam logic [7:0] OP_WR = 8'h02;
  localparam logic [7:0] OP_CHK_WR = 8'h12;
  localparam logic [7:0] OP_STORE = 8'h08;
  localparam logic [7:0] OP_RECALL = 8'h09;
  localparam logic [7:0] OP_SN_WR = 8'hC2;
  localparam logic [7:0] OP_SN_RD = 8'hC3;
  localparam logic [7:0] OP_SLEEP = 8'hB9;

  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_PROT_LO = 2;
  localparam int ST_PROT_HI = 3;
  localparam int ST_FAIL = 4;
  localparam int ST_ROLL = 5;
  localparam int ST_GUARD = 7;
  localparam logic [7:0] NV_MASK = 8'hAC;
  localparam logic [7:0] NV_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  localparam logic [5:0] BITS_OPCODE = 6'd8;
  localparam logic [5:0] BITS_ONE_BYTE = 6'd16;
  localparam logic [5:0] BITS_ADDR_END = 6'd24;
  localparam logic [5:0] BITS_WRITE_MIN = 6'd32;
  localparam logic [5:0] CNT_TOP = 6'd63;

  typedef enum logic [1:0] {PM_STANDBY, PM_OPERATING, PM_DEEP_SLEEP} power_mode_t;

  function automatic logic opcode_known(input logic [7:0] op);
    case (op)
      OP_SET_WL, OP_CLR_WL, OP_ST_RD, OP_ST_WR, OP_RD, OP_CHK_RD, OP_WR,
      OP_CHK_WR, OP_STORE, OP_RECALL, OP_SN_WR, OP_SN_RD, OP_SLEEP: opcode_known = 1'b1;
      default: opcode_known = 1'b0;
    endcase
  endfunction

  function automatic logic addr_protected(input logic [1:0] lvl, input logic [14:0] a);
    case (lvl)
      2'd0: addr_protected = 1'b0;
      2'd1: addr_protected = (a[14:13] == 2'b11);
      2'd2: addr_protected = a[14];
      default: addr_protected = 1'b1;
    endcase
  endfunction
endpackage

// *** src/bit_sync.sv ***
// Two-stage level synchroniser into the core clock domain
module bit_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// *** src/spi_link.sv ***
// Serial clock domain: bit counting, opcode and byte capture, status shift-out
module spi_link (
  input wire logic sclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic pause_n,
  input wire logic si,
  input wire logic [7:0] status_in,
  output logic [5:0] cnt_r,
  output logic [7:0] opcode_r,
  output logic [7:0] data_r,
  output logic [15:0] addr_r,
  output logic reject_r,
  output logic so_r,
  output logic drive_r
);
  logic armed_r;
  logic [6:0] sh_r;
  logic [5:0] cnt_nxt;
  logic [7:0] byte_nxt;
  logic link_clr;

  // Deselect clears the frame even inside a pause
  assign link_clr = cs_n | rst; // [RULE5]
  assign cnt_nxt = !armed_r ? 6'd1 : (cnt_r == nvram_pkg::CNT_TOP) ?
                   nvram_pkg::BITS_WRITE_MIN : cnt_r + 6'd1;
  assign byte_nxt = {sh_r, si};

  // Pause is only entered or left with the clock low, so the level seen at each
  // rising edge is the pause state; a pause never clears armed_r
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      armed_r <= 1'b0;
    end else if (pause_n) begin // [RULE1] [RULE2] [RULE4]
      armed_r <= 1'b1;
    end
  end

  // Frame registers survive deselect so the core can read them afterwards
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 6'd0;
      sh_r <= 7'd0;
      opcode_r <= 8'h00;
      data_r <= 8'h00;
      addr_r <= 16'h0000;
      reject_r <= 1'b0;
    end else if (pause_n && !cs_n) begin // [RULE3]
      cnt_r <= cnt_nxt;
      if (!armed_r) begin
        reject_r <= 1'b0;
        sh_r <= {6'd0, si}; // [RULE6] [RULE23]
      end else if (!reject_r) begin
        sh_r <= byte_nxt[6:0]; // [RULE6]
        if (cnt_nxt == nvram_pkg::BITS_OPCODE) begin
          opcode_r <= byte_nxt; // [RULE6]
          reject_r <= !nvram_pkg::opcode_known(byte_nxt); // [RULE24] [RULE9]
        end
        if (cnt_nxt == nvram_pkg::BITS_ONE_BYTE) begin
          data_r <= byte_nxt;
        end
        if (cnt_nxt == nvram_pkg::BITS_ADDR_END) begin
          addr_r <= {data_r, byte_nxt};
        end
      end
    end
  end

  // Output changes after the falling edge, status repeats MSB first
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      drive_r <= 1'b0;
      so_r <= 1'b0;
    end else if (pause_n) begin // [RULE23]
      drive_r <= armed_r && !reject_r && cnt_r >= nvram_pkg::BITS_OPCODE &&
                 opcode_r == nvram_pkg::OP_ST_RD; // [RULE24]
      so_r <= status_in[~cnt_r[2:0]];
    end
  end
endmodule

// *** dv/spi_master_model.sv ***
// SPI master model in mode 0 that drives frames into the serial nvram front end
module spi_master_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  output logic pause_n,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 80;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    pause_n = 1'b1;
  end
  // Clock stands low outside frames; input flips after release so no stale bit lingers
  task automatic frame(input logic [31:0] bits, input int n, input int pause_at,
      input bit abort, output logic [7:0] rd, output logic oe_any, output logic oe_pause);
    rd = 8'h00;
    oe_any = 1'b0;
    oe_pause = 1'b0;
    cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < n; i++) begin
      if (i == pause_at) begin
        // Let the falling edge settle first so the pending output bit still updates
        #HALF;
        pause_n = 1'b0;
        #HALF;
        // Garbage clocking while paused must leave no trace
        repeat (2) begin
          si = ~si;
          sclk = 1'b1;
          #HALF;
          sclk = 1'b0;
          #HALF;
        end
        oe_pause = so_oe;
        if (abort) begin
          cs_n = 1'b1;
          break;
        end
        pause_n = 1'b1;
        #HALF;
      end
      si = bits[31-i];
      #HALF;
      // A released output floats to the pull-up level
      rd = {rd[6:0], so_oe ? so : 1'b1};
      oe_any = oe_any | so_oe;
      sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
    end
    #HALF;
    cs_n = 1'b1;
    pause_n = 1'b1;
    si = ~si;
    #400;
  endtask
endmodule

// *** dv/serial_nvram_cmd_status_tb.sv ***
// Self-checking bench for the serial nvram command and status front end
module serial_nvram_cmd_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic guard_pin_n = 1'b1;
  logic nv_busy = 1'b0;
  logic crc_done = 1'b0;
  logic crc_bad = 1'b0;
  logic sclk, cs_n, si, pause_n, so, so_oe, lock, wake_busy;
  logic aw, cw, st, rc, snw, refused, oe_any, oe_pause;
  logic [7:0] status;
  logic [7:0] rd;
  logic [14:0] waddr;
  logic [5:0] seen = 6'h00;
  logic seen_clr = 1'b0;
  nvram_pkg::power_mode_t pmode;
  logic [7:0] ops [5] = '{8'h08, 8'h09, 8'h03, 8'h13, 8'hC3};
  logic [5:0] hits [5] = '{6'h04, 6'h08, 6'h00, 6'h00, 6'h00};
  int err_count = 0;
  int checked = 0;
  always #5 core_clk = ~core_clk;
  spi_master_model master (.sclk(sclk), .cs_n(cs_n), .si(si), .pause_n(pause_n),
    .so(so), .so_oe(so_oe));
  nvram_cmd_status dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_si(si), .spi_pause_n(pause_n), .guard_pin_n(guard_pin_n),
    .nv_busy(nv_busy), .crc_done(crc_done), .crc_bad(crc_bad), .spi_so(so),
    .spi_so_oe(so_oe), .device_status_control_r(status), .hardware_lock_mode_r(lock),
    .power_mode_r(pmode), .wake_busy_r(wake_busy), .array_write_go_r(aw),
    .checked_write_go_r(cw), .store_go_r(st), .recall_go_r(rc),
    .serial_number_write_go_r(snw), .write_refused_r(refused), .write_addr_r(waddr));
  // Pulses are one cycle wide, so keep them sticky until the next frame
  always @(posedge core_clk) seen <= seen_clr ? 6'h00 : seen | {refused, snw, rc, st, cw, aw};
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic send(input logic [31:0] bits, input int n, input int pause_at = -1);
    @(posedge core_clk);
    seen_clr <= 1'b1;
    @(posedge core_clk);
    seen_clr <= 1'b0;
    @(negedge core_clk);
    master.frame(bits, n, pause_at, 1'b0, rd, oe_any, oe_pause);
  endtask
  task automatic set_latch();
    send(32'h0600_0000, 8);
  endtask
  task automatic core_set(input logic g, input logic b, input logic d, input logic bad);
    @(posedge core_clk);
    guard_pin_n <= g;
    nv_busy <= b;
    crc_done <= d;
    crc_bad <= bad;
    @(posedge core_clk);
    crc_done <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask
  initial begin
    #400000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    check(status, 8'h00);
    check(pmode, nvram_pkg::PM_STANDBY);
    send(32'h0200_1234, 32);
    check(seen, 6'h20);
    send(32'h0600_0000, 5);
    check(status, 8'h00);
    master.frame(32'h0600_0000, 8, 4, 1'b1, rd, oe_any, oe_pause);
    check(status, 8'h00);
    set_latch();
    check(status, 8'h02);
    send(32'h0500_0000, 16);
    check(rd, 8'h02);
    check(oe_any, 1'b1);
    core_set(1'b0, 1'b0, 1'b0, 1'b0);
    send(32'h0400_0000, 8);
    check(status, 8'h00);
    core_set(1'b1, 1'b0, 1'b0, 1'b0);
    set_latch();
    send(32'h01FF_0000, 16);
    check(status, 8'hAC);
    send(32'h0500_0000, 16, 12);
    check(rd, 8'hAC);
    check(oe_pause, 1'b0);
    set_latch();
    send(32'h0200_0010, 32);
    check(seen, 6'h20);
    core_set(1'b0, 1'b0, 1'b0, 1'b0);
    check(lock, 1'b1);
    set_latch();
    send(32'h0100_0000, 16);
    check(seen, 6'h20);
    check(status, 8'hAE);
    core_set(1'b1, 1'b0, 1'b0, 1'b0);
    check(lock, 1'b0);
    send(32'h0100_0000, 16);
    check(status, 8'h00);
    set_latch();
    send(32'h0272_3455, 32);
    check(seen, 6'h01);
    check(waddr, 15'h7234);
    check(status, 8'h00);
    set_latch();
    send(32'h1200_4000, 32);
    check(seen, 6'h02);
    check(status, 8'h00);
    core_set(1'b1, 1'b0, 1'b1, 1'b1);
    check(status, 8'h10);
    core_set(1'b1, 1'b1, 1'b1, 1'b0);
    check(status, 8'h01);
    core_set(1'b1, 1'b0, 1'b0, 1'b0);
    check(status, 8'h00);
    for (int i = 0; i < 5; i++) begin
      send({ops[i], 24'h00_0000}, (i < 2) ? 8 : 32);
      check(seen, hits[i]);
    end
    set_latch();
    send(32'hC2AB_0000, 16);
    check(seen, 6'h10);
    send(32'hFF00_0000, 16);
    check(oe_any, 1'b0);
    send(32'h0400_0000, 8);
    check(status, 8'h00);
    send(32'hB900_0000, 8);
    check(pmode, nvram_pkg::PM_DEEP_SLEEP);
    set_latch();
    check(wake_busy, 1'b1);
    check(status, 8'h00);
    for (int i = 0; i < 3000 && wake_busy !== 1'b0; i++) begin
      @(posedge core_clk);
    end
    check(wake_busy, 1'b0);
    set_latch();
    check(status, 8'h02);
    give_verdict();
  end
endmodule
